/* File: hw/miirx_pkg.sv */
// Shared constants and types for the MII receive output port
package miirx_pkg;

   // Clock rates and RXCLK dividers
   localparam int unsigned     SYS_CLK_HZ   = 125_000_000;
   localparam int unsigned     RXCLK_100_HZ = 25_000_000;
   localparam int unsigned     RXCLK_10_HZ  = 2_500_000;
   localparam int unsigned     DIV_W        = 6;
   localparam logic [DIV_W-1:0] DIV_100     = DIV_W'(SYS_CLK_HZ / RXCLK_100_HZ);
   localparam logic [DIV_W-1:0] DIV_10      = DIV_W'(SYS_CLK_HZ / RXCLK_10_HZ);
   localparam logic [DIV_W-1:0] CNT_ZERO    = 6'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Nibble and buffer entry layout
   localparam int unsigned     NIB_W      = 4;
   localparam int unsigned     FIFO_DEPTH = 8;
   localparam int unsigned     ENT_ERR    = 4;
   localparam int unsigned     ENT_EOF    = 5;
   localparam int unsigned     ENT_SOF    = 6;
   localparam int unsigned     ENT_FC     = 7;
   localparam int unsigned     ENT_W      = 8;
   localparam logic [NIB_W-1:0] NIB_ZERO  = 4'h0;
   localparam logic [NIB_W-1:0] FC_NIB    = 4'hE;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded line symbol kinds
   typedef enum logic [2:0] {
      KIND_DATA = 3'h0,
      KIND_J    = 3'h1,
      KIND_K    = 3'h2,
      KIND_T    = 3'h3,
      KIND_R    = 3'h4,
      KIND_IDLE = 3'h5,
      KIND_ERR  = 3'h6
   } miirx_kind_t;

   // Line-side delimiter parser
   typedef enum logic [4:0] {
      PS_IDLE  = 5'h01,
      PS_GOT_J = 5'h02,
      PS_FRAME = 5'h04,
      PS_GOT_T = 5'h08,
      PS_FC    = 5'h10
   } miirx_pstate_t;

   // MII output sequencer
   typedef enum logic [2:0] {
      OS_IDLE    = 3'h1,
      OS_FRAME   = 3'h2,
      OS_ERR_END = 3'h4
   } miirx_ostate_t;

endpackage : miirx_pkg

/* File: hw/miirx_fifo.sv */
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/10ps
`default_nettype none

module miirx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // Write side
   input  wire logic             i_wr_clk,
   input  wire logic             i_wr_reset,
   input  wire logic             i_wr_valid,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output logic                  o_wr_ready,
   // Read side
   input  wire logic             i_rd_clk,
   input  wire logic             i_rd_reset,
   output logic                  o_rd_valid,
   output logic      [WIDTH-1:0] o_rd_data,
   input  wire logic             i_rd_ready
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wbin_r;
   logic [AW:0]      wgray_r;
   logic [AW:0]      rbin_r;
   logic [AW:0]      rgray_r;
   logic [AW:0]      rg_s1_r;
   logic [AW:0]      rg_s2_r;
   logic [AW:0]      wg_s1_r;
   logic [AW:0]      wg_s2_r;
   logic [AW:0]      wbin_nxt;
   logic [AW:0]      rbin_nxt;
   logic             full;
   logic             empty;
   logic             wr_en;
   logic             rd_en;

   // Full when the writer is a whole lap ahead
   assign full       = wgray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
   assign empty      = rgray_r == wg_s2_r;
   assign o_wr_ready = !full;
   assign o_rd_valid = !empty;
   assign o_rd_data  = mem_r[rbin_r[AW-1:0]];
   assign wr_en      = i_wr_valid && !full;
   assign rd_en      = i_rd_ready && !empty;
   assign wbin_nxt   = wbin_r + 1'b1;
   assign rbin_nxt   = rbin_r + 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_wr_clk) begin
      if (wr_en) begin
         mem_r[wbin_r[AW-1:0]] <= i_wr_data;
      end
   end

   always_ff @(posedge i_wr_clk) begin
      if (i_wr_reset) begin
         wbin_r  <= '0;
         wgray_r <= '0;
      end else if (wr_en) begin
         wbin_r  <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
   end

   // Read pointer crosses as gray code, one bit changes per step
   always_ff @(posedge i_wr_clk) begin
      if (i_wr_reset) begin
         rg_s1_r <= '0;
         rg_s2_r <= '0;
      end else begin
         rg_s1_r <= rgray_r;
         rg_s2_r <= rg_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_rd_clk) begin
      if (i_rd_reset) begin
         rbin_r  <= '0;
         rgray_r <= '0;
      end else if (rd_en) begin
         rbin_r  <= rbin_nxt;
         rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      end
   end

   always_ff @(posedge i_rd_clk) begin
      if (i_rd_reset) begin
         wg_s1_r <= '0;
         wg_s2_r <= '0;
      end else begin
         wg_s1_r <= wgray_r;
         wg_s2_r <= wg_s1_r;
      end
   end

endmodule : miirx_fifo

`default_nettype wire

/* File: hw/miirx_port.sv */
// MII receive output port: delimiter parsing, RXCLK generation, MII drive
`timescale 1ns/10ps
`default_nettype none

module miirx_port (
   // System clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_reset,
   // Decoded line stream, recovered clock domain
   input  wire logic                   i_line_clk,
   input  wire logic                   i_line_valid,
   input  wire miirx_pkg::miirx_kind_t i_line_kind,
   input  wire logic [miirx_pkg::NIB_W-1:0] i_line_nib,
   input  wire logic                   i_line_link,
   input  wire logic                   i_line_carrier,
   output logic                        o_line_ready,
   // Configuration
   input  wire logic                   i_speed_100,
   input  wire logic                   i_receive_tristate_control,
   // MII receive pins
   output logic                        o_rxclk,
   output logic                        o_rxclk_oe_n,
   output logic [miirx_pkg::NIB_W-1:0] o_rxd,
   output logic                        o_rxdv,
   output logic                        o_rxer,
   output logic                        o_rxdata_oe_n,
   output logic                        o_rxclk_from_line
);
   import miirx_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Line domain

   logic                line_rst_s1_r;
   logic                line_rst_s2_r;
   miirx_pstate_t       pstate_r;
   miirx_pstate_t       pstate_nxt;
   logic                sof_pend_r;
   logic                ovr_r;
   logic                accept;
   logic                push;
   logic                wr_ready;
   logic [ENT_W-1:0]    wr_data;
   logic                rd_valid;
   logic                rd_ready;
   logic [ENT_W-1:0]    rd_data;

   // Reset crosses into the line domain through two flops, so it releases two line clocks later
   always_ff @(posedge i_line_clk) begin
      line_rst_s1_r <= i_reset;
      line_rst_s2_r <= line_rst_s1_r;
   end

   assign accept = i_line_valid && o_line_ready;

   always_comb begin
      pstate_nxt       = pstate_r;
      push             = 1'b0;
      wr_data          = '0;
      if (accept) begin
         case (pstate_r)
            PS_IDLE: begin
               if (i_line_kind == KIND_J) begin
                  pstate_nxt = PS_GOT_J;
               end else if (i_line_kind != KIND_IDLE) begin
                  push             = 1'b1;
                  wr_data[ENT_FC]  = 1'b1;
                  pstate_nxt       = PS_FC;
               end
            end
            PS_GOT_J: begin
               if (i_line_kind == KIND_K) begin
                  pstate_nxt = PS_FRAME;
               end else begin
                  push            = 1'b1;
                  wr_data[ENT_FC] = 1'b1;
                  pstate_nxt = (i_line_kind == KIND_IDLE) ? PS_IDLE : PS_FC;
               end
            end
            PS_FRAME: begin
               if (i_line_kind == KIND_DATA) begin
                  push                   = 1'b1;
                  wr_data[NIB_W-1:0]     = i_line_nib;
                  wr_data[ENT_SOF]       = sof_pend_r;
                  wr_data[ENT_ERR]       = ovr_r;
               end else if (i_line_kind == KIND_T) begin
                  pstate_nxt = PS_GOT_T;
               end else begin
                  push             = 1'b1;
                  wr_data[ENT_EOF] = 1'b1;
                  wr_data[ENT_ERR] = 1'b1;
                  pstate_nxt = (i_line_kind == KIND_IDLE) ? PS_IDLE : PS_FC;
               end
            end
            PS_GOT_T: begin
               push             = 1'b1;
               wr_data[ENT_EOF] = 1'b1;
               wr_data[ENT_ERR] = (i_line_kind != KIND_R) || ovr_r;
               if (i_line_kind == KIND_R || i_line_kind == KIND_IDLE) begin
                  pstate_nxt = PS_IDLE;
               end else begin
                  pstate_nxt = PS_FC;
               end
            end
            PS_FC: begin
               if (i_line_kind == KIND_IDLE) begin
                  pstate_nxt = PS_IDLE;
               end
            end
            default: begin
               pstate_nxt = PS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_line_clk) begin
      if (line_rst_s2_r) begin
         pstate_r <= PS_IDLE;
      end else begin
         pstate_r <= pstate_nxt;
      end
   end

   // First data nibble of a frame carries the start mark
   always_ff @(posedge i_line_clk) begin
      if (line_rst_s2_r) begin
         sof_pend_r <= 1'b0;
      end else if (pstate_r == PS_GOT_J && pstate_nxt == PS_FRAME) begin
         sof_pend_r <= 1'b1;
      end else if (push && wr_ready) begin
         sof_pend_r <= 1'b0;
      end
   end

   // A lost entry taints the next one; ready rests a cycle after each push so none is lost
   always_ff @(posedge i_line_clk) begin
      if (line_rst_s2_r) begin
         ovr_r <= 1'b0;
      end else if (push && !wr_ready) begin
         ovr_r <= 1'b1;
      end else if (push) begin
         ovr_r <= 1'b0;
      end
   end

   always_ff @(posedge i_line_clk) begin
      if (line_rst_s2_r) begin
         o_line_ready <= 1'b0;
      end else begin
         o_line_ready <= wr_ready && !push;
      end
   end

   miirx_fifo #(
      .WIDTH (ENT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_wr_clk   (i_line_clk),
      .i_wr_reset (line_rst_s2_r),
      .i_wr_valid (push),
      .i_wr_data  (wr_data),
      .o_wr_ready (wr_ready),
      .i_rd_clk   (i_sys_clk),
      .i_rd_reset (i_reset),
      .o_rd_valid (rd_valid),
      .o_rd_data  (rd_data),
      .i_rd_ready (rd_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // System domain: synchronisers

   logic car_s1_r;
   logic car_s2_r;
   logic car_d_r;
   logic lnk_s1_r;
   logic lnk_s2_r;
   logic lnk_d_r;
   logic tri_s1_r;
   logic tri_s2_r;

   always_ff @(posedge i_sys_clk) begin
      car_s1_r <= i_line_carrier;
      car_s2_r <= car_s1_r;
      car_d_r  <= car_s2_r;
      lnk_s1_r <= i_line_link;
      lnk_s2_r <= lnk_s1_r;
      lnk_d_r  <= lnk_s2_r;
      tri_s1_r <= i_receive_tristate_control;
      tri_s2_r <= tri_s1_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // RXCLK generation

   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;
   logic [DIV_W-1:0] div_sel;
   logic [DIV_W-1:0] half;
   logic             realign;
   logic             aligned_r;
   logic             data_tick;
   miirx_ostate_t    ostate_r;

   assign div_sel = i_speed_100 ? DIV_100 : DIV_10;
   assign half    = div_sel >> 1;

   // Phase snaps to zero: at most one period lost, seen as a phase jump
   always_comb begin
      if (i_speed_100) begin
         realign = lnk_s2_r && !lnk_d_r;
      end else begin
         realign = car_s2_r && !car_d_r && !aligned_r && !o_rxdv;
      end
   end

   always_comb begin
      if (realign || cnt_r >= div_sel - 1'b1) begin
         cnt_nxt = CNT_ZERO;
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         cnt_r <= CNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Once per packet, re-armed when carrier drops
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         aligned_r <= 1'b0;
      end else if (!i_speed_100 && realign) begin
         aligned_r <= 1'b1;
      end else if (!car_s2_r) begin
         aligned_r <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_rxclk           <= 1'b0;
         o_rxclk_from_line <= 1'b0;
         o_rxclk_oe_n      <= 1'b1;
         o_rxdata_oe_n     <= 1'b1;
      end else begin
         o_rxclk           <= cnt_nxt < half;
         o_rxclk_from_line <= !i_speed_100 || lnk_s2_r;
         o_rxclk_oe_n      <= tri_s2_r;
         o_rxdata_oe_n     <= tri_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // MII output sequencer

   // Data moves on the falling edge so it is settled at the rising edge
   assign data_tick = cnt_nxt == half;
   assign rd_ready  = data_tick && ostate_r != OS_ERR_END;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ostate_r <= OS_IDLE;
         o_rxd    <= NIB_ZERO;
         o_rxdv   <= 1'b0;
         o_rxer   <= 1'b0;
      end else if (data_tick) begin
         case (ostate_r)
            OS_IDLE: begin
               o_rxd  <= NIB_ZERO;
               o_rxer <= 1'b0;
               if (rd_valid && rd_data[ENT_FC]) begin
                  o_rxer <= i_speed_100;
                  o_rxd  <= i_speed_100 ? FC_NIB : NIB_ZERO;
               end else if (rd_valid && rd_data[ENT_SOF] && !rd_data[ENT_EOF]) begin
                  o_rxdv   <= 1'b1;
                  o_rxd    <= rd_data[NIB_W-1:0];
                  o_rxer   <= rd_data[ENT_ERR] && i_speed_100;
                  ostate_r <= OS_FRAME;
               end
            end
            OS_FRAME: begin
               if (!rd_valid) begin
                  o_rxer <= i_speed_100;
               end else if (rd_data[ENT_EOF] && rd_data[ENT_ERR] && i_speed_100) begin
                  o_rxer   <= 1'b1;
                  o_rxd    <= NIB_ZERO;
                  ostate_r <= OS_ERR_END;
               end else if (rd_data[ENT_EOF]) begin
                  o_rxdv   <= 1'b0;
                  o_rxer   <= 1'b0;
                  o_rxd    <= NIB_ZERO;
                  ostate_r <= OS_IDLE;
               end else begin
                  o_rxd  <= rd_data[NIB_W-1:0];
                  o_rxer <= rd_data[ENT_ERR] && i_speed_100;
               end
            end
            OS_ERR_END: begin
               o_rxdv   <= 1'b0;
               o_rxer   <= 1'b0;
               o_rxd    <= NIB_ZERO;
               ostate_r <= OS_IDLE;
            end
            default: begin
               ostate_r <= OS_IDLE;
            end
         endcase
      end
   end

endmodule : miirx_port

`default_nettype wire

/* File: bench/miirx_port_asserts.sv */
// Pin-level checks for the MII receive output port
`timescale 1ns/10ps
`default_nettype none

module miirx_port_asserts (
   // Clock, reset and controls
   input wire logic                        i_sys_clk,
   input wire logic                        i_reset,
   input wire logic                        i_speed_100,
   input wire logic                        i_receive_tristate_control,
   // MII receive pins
   input wire logic                        o_rxclk,
   input wire logic                        o_rxclk_oe_n,
   input wire logic [miirx_pkg::NIB_W-1:0] o_rxd,
   input wire logic                        o_rxdv,
   input wire logic                        o_rxer,
   input wire logic                        o_rxdata_oe_n,
   input wire logic                        o_rxclk_from_line
);
   import miirx_pkg::*;
   logic [5:0] lock_r;
   logic       lock100;
   // Link-rise realign may stretch one phase, so wait until lock has settled
   always_ff @(posedge i_sys_clk) begin
      lock_r <= {lock_r[4:0], o_rxclk_from_line};
   end
   assign lock100 = i_speed_100 && o_rxclk_from_line && lock_r[5];
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////
   a_hi_100: assert property (lock100 && $rose(o_rxclk) |=> o_rxclk ##1 !o_rxclk)
      else $error("RXCLK high time off at 100M");
   a_lo_100: assert property (lock100 && $fell(o_rxclk) |=> !o_rxclk [*2] ##1 o_rxclk)
      else $error("RXCLK low time off at 100M");
   a_rxd_at_fall: assert property ($changed(o_rxd) || $changed(o_rxdv) || $changed(o_rxer)
      |-> $fell(o_rxclk)) else $error("receive pins moved off the RXCLK fall");
   a_oe_release: assert property ($rose(i_receive_tristate_control) |-> ##3 o_rxclk_oe_n)
      else $error("RXCLK not released");
   a_oe_drive: assert property ($fell(i_receive_tristate_control) |-> ##3 !o_rxclk_oe_n)
      else $error("RXCLK not driven");
   a_oe_pair: assert property (o_rxclk_oe_n == o_rxdata_oe_n)
      else $error("clock and data enables differ");
   a_fc_nibble: assert property (!o_rxdv && o_rxer |-> o_rxd == FC_NIB)
      else $error("false carrier code wrong");
   a_idle_zero: assert property (!o_rxdv && !o_rxer |-> o_rxd == NIB_ZERO)
      else $error("receive nibble not cleared outside frame");
   a_rxer_10m: assert property (!i_speed_100 |-> !o_rxer)
      else $error("RXER raised at 10M");
   a_line_10m: assert property (!i_speed_100 && !$past(i_reset) |-> o_rxclk_from_line)
      else $error("10M clock not taken from line");
   a_link_realign: assert property (i_speed_100 && $rose(o_rxclk_from_line) && !$past(i_reset, 2)
      |-> o_rxclk ##1 o_rxclk ##1 !o_rxclk) else $error("RXCLK not realigned on link rise");
endmodule : miirx_port_asserts

bind miirx_port miirx_port_asserts miirx_port_asserts_i (.i_sys_clk, .i_reset, .i_speed_100,
   .i_receive_tristate_control, .o_rxclk, .o_rxclk_oe_n, .o_rxd, .o_rxdv, .o_rxer,
   .o_rxdata_oe_n, .o_rxclk_from_line);
`default_nettype wire

/* File: bench/miirx_mac_model.sv */
// Behavioural MAC receive side sampling the MII
`timescale 1ns/10ps
`default_nettype none

module miirx_mac_model (
   // MII receive pins
   input  wire logic        i_rxclk,
   input  wire logic        i_rxdv,
   input  wire logic        i_rxer,
   input  wire logic [3:0]  i_rxd,
   // Collected frame
   input  wire logic        i_clr,
   output logic      [63:0] o_data,
   output logic      [7:0]  o_nibs,
   output logic      [7:0]  o_errs
);
   // Rising edges only, so a phase jump of the clock does no harm
   always @(posedge i_rxclk or posedge i_clr) begin
      if (i_clr) begin
         o_data <= 64'h0;
         o_nibs <= 8'h00;
         o_errs <= 8'h00;
      end else begin
         if (i_rxdv && !i_rxer) begin
            o_data <= {i_rxd, o_data[63:4]};
            o_nibs <= o_nibs + 8'h01;
         end
         if (i_rxer) begin
            o_errs <= o_errs + 8'h01;
         end
      end
   end
endmodule : miirx_mac_model
`default_nettype wire

/* File: bench/mii_receive_output_port_test.sv */
// Self-checking bench for the MII receive output port
`timescale 1ns/10ps
`default_nettype none

module mii_receive_output_port_test;
   import miirx_pkg::*;
   localparam logic [63:0] W = 64'h5A3C_96F0_0FE1_D2B7;
   logic             i_sys_clk, i_reset, i_line_clk, i_line_valid, i_line_link;
   logic             i_line_carrier, i_speed_100, i_receive_tristate_control;
   logic             o_line_ready, o_rxclk, o_rxclk_oe_n, o_rxdv, o_rxer;
   logic             o_rxdata_oe_n, o_rxclk_from_line, mac_clr, stalled;
   logic [NIB_W-1:0] i_line_nib, o_rxd;
   logic [63:0]      mac_data;
   logic [7:0]       mac_nibs, mac_errs;
   miirx_kind_t      i_line_kind;
   int               fails = 0;
   int               tests_run = 0;
   int               cyc = 0;

   initial begin
      i_sys_clk = 0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      i_line_clk = 0;
      #1.7;
      forever #6 i_line_clk = ~i_line_clk;
   end

   miirx_port miirx_port_i (.i_sys_clk, .i_reset, .i_line_clk, .i_line_valid, .i_line_kind,
      .i_line_nib, .i_line_link, .i_line_carrier, .o_line_ready, .i_speed_100,
      .i_receive_tristate_control, .o_rxclk, .o_rxclk_oe_n, .o_rxd, .o_rxdv, .o_rxer,
      .o_rxdata_oe_n, .o_rxclk_from_line);
   miirx_mac_model miirx_mac_model_i (.i_rxclk(o_rxclk), .i_rxdv(o_rxdv), .i_rxer(o_rxer),
      .i_rxd(o_rxd), .i_clr(mac_clr), .o_data(mac_data), .o_nibs(mac_nibs), .o_errs(mac_errs));

   ////////////////////////////////////////
   // Whole run needs some 2000 cycles
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   task automatic do_reset(input logic spd);
      @(negedge i_sys_clk);
      i_reset = 1;
      i_speed_100 = spd;
      repeat (8) @(negedge i_sys_clk);
      i_reset = 0;
      while (o_line_ready !== 1) @(negedge i_sys_clk);
   endtask : do_reset

   task automatic sym(input miirx_kind_t k, input logic [NIB_W-1:0] n);
      @(negedge i_line_clk);
      i_line_valid = 1;
      i_line_kind = k;
      i_line_nib = n;
      while (o_line_ready !== 1) begin
         stalled = 1;
         @(negedge i_line_clk);
      end
      @(posedge i_line_clk);
   endtask : sym

   // Released data shows the inverse so stale nibbles cannot pass
   task automatic frame(input logic [63:0] w, input int n, input logic bad);
      mac_clr = 1;
      @(negedge i_line_clk);
      mac_clr = 0;
      i_line_carrier = 1;
      sym(KIND_J, NIB_ZERO);
      sym(KIND_K, NIB_ZERO);
      for (int i = 0; i < n; i++) sym(KIND_DATA, w[4*i +: 4]);
      if (bad) begin
         sym(KIND_ERR, NIB_ZERO);
      end else begin
         sym(KIND_T, NIB_ZERO);
         sym(KIND_R, NIB_ZERO);
      end
      sym(KIND_IDLE, NIB_ZERO);
      @(negedge i_line_clk);
      i_line_valid = 0;
      i_line_carrier = 0;
      i_line_nib = ~i_line_nib;
   endtask : frame

   task automatic drain();
      int q;
      q = 0;
      while (q < 120) begin
         @(negedge i_sys_clk);
         q = (o_rxdv || o_rxer) ? 0 : q + 1;
      end
   endtask : drain

   task automatic hi_time(input int exp);
      int n;
      n = 0;
      while (o_rxclk !== 0) @(negedge i_sys_clk);
      while (o_rxclk !== 1) @(negedge i_sys_clk);
      while (o_rxclk === 1) begin
         n++;
         @(negedge i_sys_clk);
      end
      chk("rxclk high", 64'(n), 64'(exp));
      $display("clock test done");
   endtask : hi_time

   task automatic t_frame();
      stalled = 0;
      frame(W, 16, 0);
      drain();
      chk("nibbles", mac_data, W);
      chk("nibble count", 64'(mac_nibs), 64'h10);
      chk("rxer count", 64'(mac_errs), 64'h0);
      $display("frame test done");
   endtask : t_frame

   task automatic t_err(input logic [7:0] exp_err);
      frame(W, 2, 1);
      drain();
      chk("err nibbles", mac_data, {W[7:0], 56'h0});
      chk("err rxer", 64'(mac_errs), 64'(exp_err));
      $display("error test done");
   endtask : t_err

   task automatic t_fc();
      frame(W, 0, 0);
      mac_clr = 1;
      @(negedge i_sys_clk);
      mac_clr = 0;
      i_line_carrier = 1;
      sym(KIND_DATA, 4'h3);
      sym(KIND_IDLE, NIB_ZERO);
      @(negedge i_line_clk);
      i_line_valid = 0;
      i_line_carrier = 0;
      while (o_rxer !== 1) @(negedge i_sys_clk);
      chk("fc nibble", 64'(o_rxd), 64'(FC_NIB));
      drain();
      chk("fc count", 64'({mac_errs, mac_nibs}), 64'h0100);
      $display("false carrier test done");
   endtask : t_fc

   task automatic t_tri();
      @(negedge i_sys_clk);
      i_receive_tristate_control = 1;
      repeat (3) @(negedge i_sys_clk);
      chk("oe released", 64'({o_rxclk_oe_n, o_rxdata_oe_n}), 64'h3);
      i_receive_tristate_control = 0;
      repeat (3) @(negedge i_sys_clk);
      chk("oe driven", 64'({o_rxclk_oe_n, o_rxdata_oe_n}), 64'h0);
      $display("tristate test done");
   endtask : t_tri

   task automatic t_link();
      @(negedge i_line_clk);
      i_line_link = 0;
      repeat (10) @(negedge i_sys_clk);
      chk("ref clock", 64'(o_rxclk_from_line), 64'h0);
      hi_time(2);
      @(negedge i_line_clk);
      i_line_link = 1;
      repeat (10) @(negedge i_sys_clk);
      chk("link back", 64'(o_rxclk_from_line), 64'h1);
      $display("link test done");
   endtask : t_link

   initial begin
      i_reset = 1;
      i_speed_100 = 1;
      i_line_valid = 0;
      i_line_kind = KIND_IDLE;
      i_line_nib = NIB_ZERO;
      i_line_link = 1;
      i_line_carrier = 0;
      i_receive_tristate_control = 0;
      mac_clr = 0;
      stalled = 0;
      do_reset(1);
      t_frame();
      chk("from line", 64'(o_rxclk_from_line), 64'h1);
      t_err(8'h01);
      t_fc();
      t_tri();
      t_link();
      do_reset(0);
      hi_time(int'(DIV_10) / 2);
      t_frame();
      chk("buffer stall", 64'(stalled), 64'h1);
      chk("line clock", 64'(o_rxclk_from_line), 64'h1);
      t_err(8'h00);
      give_verdict();
   end
endmodule : mii_receive_output_port_test
`default_nettype wire
